// ### testbench/lpv_handler_tb_top.sv
// Self-checking testbench for the link power and vendor message handler
`timescale 1ns/1ps
`default_nettype none
module lpv_handler_tb_top;
  import lpv_pkg::*;
  // Command-type codes, values arbitrary
  localparam lpv_octet_type PM_T = 8'h21;
  localparam lpv_octet_type VN_T = 8'h22;
  localparam lpv_octet_type VL_T = 8'h23;
  logic          core_clk, rst, slow, local_busy, local_unwanted, req_start, vend_recognised;
  logic          rx_valid, rx_last, peer_tx_active, tx_ready, tx_valid, tx_last, tx_enable;
  logic          vend_req_seen, vend_req_low, pm_req_seen, pm_outcome_valid, pm_granted;
  logic          tx_stopped, got_grant;
  lpv_octet_type rx_data, tx_data, pm_reason, got_reason;
  int            n_mismatch, num_checks, exp_msgs, n_seen, n_out, n_stop, n_vend;

  lpv_handler #(.QUIET_CYC(2)) i_dut (
    .core_clk(core_clk), .rst(rst), .pm_type_code(PM_T), .vend_type_code(VN_T),
    .vend_lo_type_code(VL_T), .rx_valid(rx_valid), .rx_last(rx_last), .rx_data(rx_data),
    .peer_tx_active(peer_tx_active), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_data(tx_data), .tx_enable(tx_enable), .local_busy(local_busy),
    .local_unwanted(local_unwanted), .req_start(req_start),
    .vend_recognised(vend_recognised), .vend_req_seen(vend_req_seen),
    .vend_req_low(vend_req_low), .pm_req_seen(pm_req_seen),
    .pm_outcome_valid(pm_outcome_valid), .pm_granted(pm_granted), .pm_reason(pm_reason),
    .tx_stopped(tx_stopped));

  lpv_peer_model i_peer (
    .core_clk(core_clk), .slow(slow), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_last(rx_last),
    .rx_data(rx_data), .peer_tx_active(peer_tx_active));

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  // Count the handler's report pulses and keep the last outcome
  always @(posedge core_clk) begin
    if (pm_req_seen === 1'b1) n_seen++;
    if (vend_req_seen === 1'b1) n_vend++;
    if (tx_stopped === 1'b1) n_stop++;
    if (pm_outcome_valid === 1'b1) begin
      n_out++;
      got_grant = pm_granted;
      got_reason = pm_reason;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    local_busy <= 1'b0;
    local_unwanted <= 1'b0;
    req_start <= 1'b0;
    vend_recognised <= 1'b0;
    slow <= 1'b0;
    i_peer.restart();
    repeat (20) @(posedge core_clk);
    {n_seen, n_out, n_stop, n_vend} = '0;
    exp_msgs = i_peer.n_msgs;
    rst <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic pulse_req();
    req_start <= 1'b1;
    @(posedge core_clk);
    req_start <= 1'b0;
  endtask

  // Wait for the next whole message and compare it octet by octet
  task automatic exp_msg(input lpv_octet_type e[$], input string what);
    int k;
    k = 0;
    while (i_peer.n_msgs == exp_msgs && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    exp_msgs++;
    check(i_peer.n_msgs, exp_msgs, {what, " count"});
    check(i_peer.last_msg.size(), e.size(), {what, " length"});
    foreach (e[i]) check(i_peer.last_msg[i], e[i], what);
  endtask

  task automatic no_msg(input string what);
    repeat (40) @(posedge core_clk);
    check(i_peer.n_msgs, exp_msgs, what);
  endtask

  task automatic wait_stop();
    int k;
    k = 0;
    while (tx_enable !== 1'b0 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
  endtask

  // Far end asks, handler grants through a stalling transport, then waits for silence
  task automatic t_grant();
    do_reset();
    slow <= 1'b1;
    i_peer.send('{PM_T, 8'h01, 8'h03});
    exp_msg('{PM_T, 8'h80}, "grant");
    check(n_seen, 1, "request seen");
    repeat (10) @(posedge core_clk);
    check(tx_enable, 1'b1, "enable while peer talks");
    check(i_peer.n_msgs, exp_msgs, "single response");
    i_peer.quiet();
    wait_stop();
    check(tx_enable, 1'b0, "granter stops");
    @(posedge core_clk);
    check(n_stop, 1, "stop reported");
  endtask

  // Rejects: invalid state wins over busy and unwanted
  task automatic t_reject();
    lpv_octet_type st[4] = '{8'h05, 8'h03, 8'h03, 8'h00};
    logic          bz[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic          uw[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    lpv_octet_type rs[4] = '{8'h02, 8'h01, 8'h03, 8'h02};
    for (int i = 0; i < 4; i++) begin
      do_reset();
      local_busy <= bz[i];
      local_unwanted <= uw[i];
      i_peer.send('{PM_T, 8'h01, st[i]});
      exp_msg('{PM_T, 8'h81, rs[i]}, "reject");
      no_msg("extra response");
      check(tx_enable, 1'b1, "no stop on reject");
    end
  endtask

  // Handler originates: first rejected, then granted
  task automatic t_own();
    do_reset();
    pulse_req();
    exp_msg('{PM_T, 8'h01, 8'h03}, "own request");
    i_peer.send('{PM_T, 8'h81, 8'h01});
    repeat (5) @(posedge core_clk);
    check(n_out, 1, "outcome pulse");
    check({got_grant, got_reason}, {1'b0, 8'h01}, "reject outcome");
    check(tx_enable, 1'b1, "keeps sending after reject");
    pulse_req();
    exp_msg('{PM_T, 8'h01, 8'h03}, "second request");
    i_peer.send('{PM_T, 8'h80});
    wait_stop();
    check(tx_enable, 1'b0, "requester stops");
    @(posedge core_clk);
    check({got_grant, got_reason}, {1'b1, 8'h00}, "grant outcome");
    check(n_stop, 1, "stop reported");
    i_peer.send('{PM_T, 8'h01, 8'h03});
    no_msg("silent after stop");
  endtask

  // Reject answer first, then own request straight after; a granter goes quiet instead
  task automatic t_cross();
    do_reset();
    local_unwanted <= 1'b1;
    i_peer.send('{PM_T, 8'h01, 8'h03});
    pulse_req();
    exp_msg('{PM_T, 8'h81, 8'h03}, "answer first");
    exp_msg('{PM_T, 8'h01, 8'h03}, "own after answer");
  endtask

  // Vendor requests of both priorities, recognised and not, and reserved second octets
  task automatic t_vendor();
    lpv_octet_type ty[2] = '{VN_T, VL_T};
    lpv_octet_type an[2] = '{8'h80, 8'h81};
    for (int i = 0; i < 2; i++) begin
      do_reset();
      vend_recognised <= (i == 0);
      i_peer.send('{ty[i], 8'h01, 8'h0B, 8'h5C, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC});
      exp_msg('{ty[i], an[i]}, "vendor answer");
      check(vend_req_low, (i == 1), "vendor priority");
      check(n_vend, 1, "vendor seen");
    end
    i_peer.send('{VN_T, 8'h02, 8'h0B, 8'h5C, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A});
    no_msg("reserved vendor octet");
    i_peer.send('{PM_T, 8'h02, 8'h03});
    no_msg("reserved power octet");
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {slow, local_busy, local_unwanted, req_start, vend_recognised} = '0;
    n_mismatch = 0;
    num_checks = 0;
    t_grant();
    t_reject();
    t_own();
    t_cross();
    t_vendor();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### testbench/lpv_peer_model.sv
// Far-end line transceiver model facing the handler's overhead channel
`timescale 1ns/1ps
`default_nettype none
module lpv_peer_model (
  input  wire logic                   core_clk,
  input  wire logic                   slow,
  input  wire logic                   tx_valid,
  input  wire logic                   tx_last,
  input  wire lpv_pkg::lpv_octet_type tx_data,
  output logic                        tx_ready,
  output logic                        rx_valid,
  output logic                        rx_last,
  output lpv_pkg::lpv_octet_type      rx_data,
  output logic                        peer_tx_active
);
  import lpv_pkg::*;
  lpv_octet_type cur_q[$];
  lpv_octet_type last_msg[$];
  int            n_msgs;

  // Quiet receive lanes, far end talking from the start
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = 8'hA5;
    peer_tx_active = 1'b1;
    n_msgs = 0;
  end

  // Accept at once, or stall every other cycle when slow
  always @(posedge core_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // Gather the handler's octets into whole messages
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      cur_q.push_back(tx_data);
      if (tx_last === 1'b1) begin
        last_msg = cur_q;
        cur_q.delete();
        n_msgs++;
      end
    end
  end

  // Send one message, octet 1 first, one octet a cycle
  task automatic send(input lpv_octet_type m[$]);
    foreach (m[i]) begin
      rx_valid <= 1'b1;
      rx_last  <= (i == m.size() - 1);
      rx_data  <= m[i];
      @(posedge core_clk);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~m[m.size() - 1]; // Released lane no longer shows the last octet
  endtask

  // Stop transmitting after a grant to our own request
  task automatic quiet();
    peer_tx_active <= 1'b0;
  endtask

  // Fresh start after a reset of the handler
  task automatic restart();
    peer_tx_active <= 1'b1;
    cur_q.delete();
  endtask
endmodule
`default_nettype wire

// ### verilog/lpv_defines.svh
// Constants for the link power and vendor message handler
`ifndef LPV_DEFINES_SVH
`define LPV_DEFINES_SVH
`define LPV_OCT_REQ        8'h01
`define LPV_OCT_GRANT      8'h80
`define LPV_OCT_REJECT     8'h81
`define LPV_STATE_IDLE     8'h03
`define LPV_RSN_BUSY       8'h01
`define LPV_RSN_INVALID    8'h02
`define LPV_RSN_UNWANTED   8'h03
`define LPV_PM_REQ_LEN     3
`define LPV_PM_REJ_LEN     3
`define LPV_ACK_LEN        2
`define LPV_VID_FIRST      3
`define LPV_VID_LAST       8
`define LPV_VMSG_FIRST     9
`define LPV_QUIET_NS       1000
`define LPV_CLK_NS         20
`define LPV_QUIET_CYC      ((`LPV_QUIET_NS + `LPV_CLK_NS - 1) / `LPV_CLK_NS)
`endif

// ### verilog/lpv_handler.sv
// Link power and vendor message handler: answers and originates requests
//
// Notes on behaviour
// - Power request: three octets, 01, state
// - Either end may originate power request
// - First octet is the power command type
// - Grant two octets 80; reject 81+reason
// - Only defined values sent in octets 2-3
// - Exactly one response per power request; none once in the quiet state (code sends none to one arriving while one is pending or in LPV_TX_WATCH)
// - State other than 03 rejected reason 02
// - Valid request may reject busy or unwanted
// - Responder may start own request immediately
// - Requester stops transmitting on grant
// - Granter stops once peer stopped transmitting
// - Vendor request: 01, six-octet id, message
// - Vendor first octet normal or low type
// - Vendor answer 80 recognised, else 81
// - Identifier: country then provider code
// - Vendor message is vendor-specific content
`timescale 1ns/1ps
`default_nettype none
`include "lpv_defines.svh"
module lpv_handler #(
  parameter int QUIET_CYC = `LPV_QUIET_CYC
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire lpv_pkg::lpv_octet_type pm_type_code,
  input  wire lpv_pkg::lpv_octet_type vend_type_code,
  input  wire lpv_pkg::lpv_octet_type vend_lo_type_code,
  input  wire logic            rx_valid,
  input  wire logic            rx_last,
  input  wire lpv_pkg::lpv_octet_type rx_data,
  input  wire logic            peer_tx_active,
  input  wire logic            tx_ready,
  output logic                 tx_valid,
  output logic                 tx_last,
  output lpv_pkg::lpv_octet_type tx_data,
  output logic                 tx_enable,
  input  wire logic            local_busy,
  input  wire logic            local_unwanted,
  input  wire logic            req_start,
  input  wire logic            vend_recognised,
  output logic                 vend_req_seen,
  output logic                 vend_req_low,
  output logic                 pm_req_seen,
  output logic                 pm_outcome_valid,
  output logic                 pm_granted,
  output lpv_pkg::lpv_octet_type pm_reason,
  output logic                 tx_stopped
);
  import lpv_pkg::*;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  logic          msg_done;
  lpv_msg_type   msg_kind;
  lpv_octet_type oct2;
  lpv_octet_type oct3;
  logic [9:0]    msg_len;
  logic          prio_low;

  lpv_rx_parse u_rx (
    .core_clk          (core_clk),
    .rst               (rst),
    .rx_valid          (rx_valid),
    .rx_last           (rx_last),
    .rx_data           (rx_data),
    .pm_type_code      (pm_type_code),
    .vend_type_code    (vend_type_code),
    .vend_lo_type_code (vend_lo_type_code),
    .vend_ok_in        (vend_recognised),
    .msg_done          (msg_done),
    .msg_kind          (msg_kind),
    .oct2              (oct2),
    .oct3              (oct3),
    .msg_len           (msg_len),
    .vend_prio_low     (prio_low)
  );

  // ----------------------------------------------------------------
  // Message classification
  // ----------------------------------------------------------------
  wire logic is_pm_w;
  wire logic pm_req_w;
  wire logic pm_grant_w;
  wire logic pm_reject_w;
  wire logic vend_req_w;
  wire logic state_ok_w;
  assign is_pm_w     = msg_done && (msg_kind == LPV_MSG_PM);
  assign pm_req_w    = is_pm_w && (oct2 == `LPV_OCT_REQ)
                       && (msg_len == 10'(`LPV_PM_REQ_LEN));
  assign pm_grant_w  = is_pm_w && (oct2 == `LPV_OCT_GRANT)
                       && (msg_len == 10'(`LPV_ACK_LEN));
  assign pm_reject_w = is_pm_w && (oct2 == `LPV_OCT_REJECT)
                       && (msg_len == 10'(`LPV_PM_REJ_LEN));
  // Vendor request needs the full identifier; message may be empty
  assign vend_req_w  = msg_done && (msg_kind == LPV_MSG_VEND)
                       && (oct2 == `LPV_OCT_REQ)
                       && (msg_len >= 10'(`LPV_VID_LAST));
  assign state_ok_w  = (oct3 == `LPV_STATE_IDLE);

  // Response reason: invalid first, then busy, then unwanted
  wire lpv_octet_type reason_w;
  wire logic          grant_w;
  assign reason_w = !state_ok_w     ? `LPV_RSN_INVALID :
                    local_busy      ? `LPV_RSN_BUSY :
                    local_unwanted  ? `LPV_RSN_UNWANTED : 8'h00;
  assign grant_w  = state_ok_w && !local_busy && !local_unwanted;

  // ----------------------------------------------------------------
  // Transmit side and control state
  // ----------------------------------------------------------------
  lpv_tx_state_type st_r;
  lpv_tx_state_type st_nxt;
  logic          tg_start;
  lpv_octet_type tg_o1;
  lpv_octet_type tg_o2;
  lpv_octet_type tg_o3;
  logic [1:0]    tg_len;
  logic          tg_busy;
  logic          tg_done;
  logic          pend_resp_r;
  lpv_octet_type pend_o1_r;
  lpv_octet_type pend_o2_r;
  lpv_octet_type pend_o3_r;
  logic [1:0]    pend_len_r;
  logic          pend_req_r;
  logic          awaiting_r;
  logic          granter_r;
  logic [15:0]   quiet_cnt_r;
  logic [2:0]    peer_sync_r;
  logic          peer_act_r;

  lpv_tx_gen u_tx (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (tg_start),
    .o1       (tg_o1),
    .o2       (tg_o2),
    .o3       (tg_o3),
    .len      (tg_len),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_last  (tx_last),
    .tx_data  (tx_data),
    .busy     (tg_busy),
    .done     (tg_done)
  );

  // Responses go before a locally started request
  wire logic send_req_w;
  assign send_req_w = pend_req_r && !pend_resp_r && !awaiting_r;
  assign tg_start = (st_r == LPV_TX_IDLE) && !tg_busy && (pend_resp_r || send_req_w);
  assign tg_o1    = pend_resp_r ? pend_o1_r : pm_type_code;
  assign tg_o2    = pend_resp_r ? pend_o2_r : `LPV_OCT_REQ;
  assign tg_o3    = pend_resp_r ? pend_o3_r : `LPV_STATE_IDLE;
  assign tg_len   = pend_resp_r ? pend_len_r : 2'(`LPV_PM_REQ_LEN);

  // Peer activity passes three flops; change taken when last two agree
  wire logic peer_agree_w;
  assign peer_agree_w = (peer_sync_r[1] == peer_sync_r[2]);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peer_sync_r <= 3'h7;                                                    // Matches active-at-reset
      peer_act_r  <= 1'b1;
    end else begin
      peer_sync_r <= {peer_sync_r[1:0], peer_tx_active};
      if (peer_agree_w) peer_act_r <= peer_sync_r[2];
    end
  end

  // State transitions
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      LPV_TX_IDLE: begin
        if (tg_start) st_nxt = LPV_TX_SEND;
      end
      LPV_TX_SEND: begin
        if (tg_done) st_nxt = granter_r ? LPV_TX_WATCH : LPV_TX_IDLE;
      end
      LPV_TX_WATCH: begin
        if (!peer_act_r) st_nxt = LPV_TX_QUIET;
      end
      LPV_TX_QUIET: begin
        st_nxt = LPV_TX_QUIET;
      end
      default: begin
        st_nxt = LPV_TX_IDLE;
      end
    endcase
    if (pm_grant_w && awaiting_r) st_nxt = LPV_TX_QUIET;
  end

  // Pending response capture: one answer per request arriving while none is pending, outside the quiet state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_resp_r <= 1'b0;
      pend_o1_r   <= 8'h00;
      pend_o2_r   <= 8'h00;
      pend_o3_r   <= 8'h00;
      pend_len_r  <= 2'h0;
      granter_r   <= 1'b0;
    end else begin
      if (tg_start && pend_resp_r) pend_resp_r <= 1'b0;
      if (pm_req_w && !pend_resp_r && (st_r != LPV_TX_QUIET)) begin
        pend_resp_r <= 1'b1;
        pend_o1_r   <= pm_type_code;
        pend_o2_r   <= grant_w ? `LPV_OCT_GRANT : `LPV_OCT_REJECT;
        pend_o3_r   <= reason_w;
        pend_len_r  <= grant_w ? 2'(`LPV_ACK_LEN) : 2'(`LPV_PM_REJ_LEN);
        granter_r   <= grant_w;
      end else if (vend_req_w && !pend_resp_r && (st_r != LPV_TX_QUIET)) begin
        pend_resp_r <= 1'b1;
        pend_o1_r   <= prio_low ? vend_lo_type_code : vend_type_code;
        pend_o2_r   <= vend_recognised ? `LPV_OCT_GRANT : `LPV_OCT_REJECT;
        pend_o3_r   <= 8'h00;
        pend_len_r  <= 2'(`LPV_ACK_LEN);
        granter_r   <= 1'b0;
      end
    end
  end

  // Local request bookkeeping and outcome report
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r             <= LPV_TX_IDLE;
      pend_req_r       <= 1'b0;
      awaiting_r       <= 1'b0;
      pm_outcome_valid <= 1'b0;
      pm_granted       <= 1'b0;
      pm_reason        <= 8'h00;
      tx_stopped       <= 1'b0;
      pm_req_seen      <= 1'b0;
      vend_req_seen    <= 1'b0;
      vend_req_low     <= 1'b0;
      quiet_cnt_r      <= 16'h0000;
    end else begin
      st_r             <= st_nxt;
      pm_outcome_valid <= 1'b0;
      tx_stopped       <= 1'b0;
      pm_req_seen      <= pm_req_w;
      vend_req_seen    <= vend_req_w;
      if (vend_req_w) vend_req_low <= prio_low;
      if (req_start && (st_r != LPV_TX_QUIET)) pend_req_r <= 1'b1;
      if (tg_start && !pend_resp_r) begin
        pend_req_r <= 1'b0;
        awaiting_r <= 1'b1;
      end
      if (awaiting_r && (pm_grant_w || pm_reject_w)) begin
        awaiting_r       <= 1'b0;
        pm_outcome_valid <= 1'b1;
        pm_granted       <= pm_grant_w;
        pm_reason        <= pm_grant_w ? 8'h00 : oct3;
      end
      if ((st_nxt == LPV_TX_QUIET) && (st_r != LPV_TX_QUIET)) begin
        tx_stopped  <= 1'b1;
        quiet_cnt_r <= 16'(QUIET_CYC);
      end else if (quiet_cnt_r != 16'h0000) begin
        quiet_cnt_r <= quiet_cnt_r - 16'h0001;
      end
    end
  end

  // Transmitter enable drops in the quiet state
  assign tx_enable = (st_r != LPV_TX_QUIET);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence req_in_s;
    pm_req_w && !pend_resp_r && (st_r != LPV_TX_QUIET);
  endsequence

  sequence busy_reject_s;
    req_in_s and (state_ok_w && local_busy);
  endsequence

  property one_resp_p;
    @(posedge core_clk) disable iff (rst)
    req_in_s |=> pend_resp_r;
  endproperty

  one_resp_a: assert property (one_resp_p)
    else $error("request did not queue a response");

  invalid_state_a: assert property (@(posedge core_clk) disable iff (rst)
    (req_in_s and !state_ok_w) |=> (pend_o2_r == `LPV_OCT_REJECT)
      && (pend_o3_r == `LPV_RSN_INVALID))
    else $error("bad state not rejected as invalid");

  busy_reason_a: assert property (@(posedge core_clk) disable iff (rst)
    busy_reject_s |=> (pend_o3_r == `LPV_RSN_BUSY) && (pend_len_r == 2'h3))
    else $error("busy reject wrong");

  grant_len_a: assert property (@(posedge core_clk) disable iff (rst)
    (req_in_s and grant_w) |=> (pend_o2_r == `LPV_OCT_GRANT) && (pend_len_r == 2'h2))
    else $error("grant response malformed");

  grant_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    (awaiting_r && pm_grant_w) |=> !tx_enable ##1 !tx_enable)
    else $error("transmitter not stopped after grant");

  peer_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == LPV_TX_WATCH && !peer_act_r) |=> (st_r == LPV_TX_QUIET))
    else $error("granter kept transmitting after peer stopped");

  outcome_a: assert property (@(posedge core_clk) disable iff (rst)
    (awaiting_r && pm_reject_w) |=> pm_outcome_valid && !pm_granted && (pm_reason == $past(oct3)))
    else $error("reject outcome not reported");

  req_octets_a: assert property (@(posedge core_clk) disable iff (rst)
    (tg_start && !pend_resp_r) |-> (tg_len == 2'h3) && (tg_o3 == `LPV_STATE_IDLE)
      ##1 tx_valid && (tx_data == pm_type_code))
    else $error("request octets wrong");

  quiet_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (quiet_cnt_r != 16'h0000) |-> !tx_enable)
    else $error("transmitter enabled during quiet count");

  vend_ack_a: assert property (@(posedge core_clk) disable iff (rst)
    (vend_req_w && !pend_resp_r && st_r != LPV_TX_QUIET && !vend_recognised)
      |=> (pend_o2_r == `LPV_OCT_REJECT) && (pend_len_r == 2'h2))
    else $error("unrecognised vendor request not refused");
endmodule
`default_nettype wire

// ### verilog/lpv_pkg.sv
// Types shared by the link power and vendor message handler
package lpv_pkg;
  typedef logic [7:0] lpv_octet_type;
  typedef enum logic [1:0] {
    LPV_MSG_NONE  = 2'b00,
    LPV_MSG_PM    = 2'b01,
    LPV_MSG_VEND  = 2'b10
  } lpv_msg_type;
  typedef enum logic [2:0] {
    LPV_TX_IDLE   = 3'b000,
    LPV_TX_SEND   = 3'b001,
    LPV_TX_WAIT   = 3'b010,
    LPV_TX_QUIET  = 3'b011,
    LPV_TX_WATCH  = 3'b100
  } lpv_tx_state_type;
endpackage

// ### verilog/lpv_rx_parse.sv
// Receive parser: classifies one incoming overhead message octet by octet
`timescale 1ns/1ps
`default_nettype none
`include "lpv_defines.svh"
module lpv_rx_parse (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            rx_valid,
  input  wire logic            rx_last,
  input  wire lpv_pkg::lpv_octet_type rx_data,
  input  wire lpv_pkg::lpv_octet_type pm_type_code,
  input  wire lpv_pkg::lpv_octet_type vend_type_code,
  input  wire lpv_pkg::lpv_octet_type vend_lo_type_code,
  input  wire logic            vend_ok_in,
  output logic                 msg_done,
  output lpv_pkg::lpv_msg_type msg_kind,
  output lpv_pkg::lpv_octet_type oct2,
  output lpv_pkg::lpv_octet_type oct3,
  output logic [9:0]           msg_len,
  output logic                 vend_prio_low
);
  import lpv_pkg::*;
  logic [9:0]   idx_r;
  lpv_msg_type  kind_r;
  logic         low_r;
  wire logic    first_w;
  wire lpv_msg_type kind_first_w;
  assign first_w = (idx_r == 10'h000);
  // First octet carries the command type
  assign kind_first_w = (rx_data == pm_type_code) ? LPV_MSG_PM :
                        ((rx_data == vend_type_code) || (rx_data == vend_lo_type_code))
                        ? LPV_MSG_VEND : LPV_MSG_NONE;
  // Octet counter and captured header fields
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_r <= 10'h000;
      kind_r <= LPV_MSG_NONE;
      low_r <= 1'b0;
      oct2 <= 8'h00;
      oct3 <= 8'h00;
      msg_len <= 10'h000;
      msg_done <= 1'b0;
      msg_kind <= LPV_MSG_NONE;
      vend_prio_low <= 1'b0;
    end else begin
      msg_done <= 1'b0;
      if (rx_valid) begin
        if (first_w) begin
          kind_r <= kind_first_w;
          low_r <= (rx_data == vend_lo_type_code);
        end
        if (idx_r == 10'h001) oct2 <= rx_data;
        if (idx_r == 10'h002) oct3 <= rx_data;
        if (rx_last) begin
          idx_r <= 10'h000;
          msg_done <= 1'b1;
          msg_kind <= first_w ? kind_first_w : kind_r;
          msg_len <= idx_r + 10'h001;
          vend_prio_low <= first_w ? (rx_data == vend_lo_type_code) : low_r;
        end else if (idx_r != 10'h3FF) begin
          idx_r <= idx_r + 10'h001;
        end
      end
    end
  end
  // Vendor check input is held by the caller until message end
  wire logic unused_w;
  assign unused_w = vend_ok_in;
endmodule
`default_nettype wire

// ### verilog/lpv_tx_gen.sv
// Transmit generator: serialises a response or request of up to three octets
`timescale 1ns/1ps
`default_nettype none
module lpv_tx_gen (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            start,
  input  wire lpv_pkg::lpv_octet_type o1,
  input  wire lpv_pkg::lpv_octet_type o2,
  input  wire lpv_pkg::lpv_octet_type o3,
  input  wire logic [1:0]      len,
  input  wire logic            tx_ready,
  output logic                 tx_valid,
  output logic                 tx_last,
  output lpv_pkg::lpv_octet_type tx_data,
  output logic                 busy,
  output logic                 done
);
  import lpv_pkg::*;
  lpv_octet_type b1_r;
  lpv_octet_type b2_r;
  lpv_octet_type b3_r;
  logic [1:0]   left_r;
  assign tx_valid = (left_r != 2'h0);
  assign busy     = tx_valid;
  assign tx_last  = (left_r == 2'h1);
  assign tx_data  = b1_r;
  // Shift octets out while the transport accepts them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
      left_r <= 2'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !tx_valid) begin
        b1_r <= o1;
        b2_r <= o2;
        b3_r <= o3;
        left_r <= len;
      end else if (tx_valid && tx_ready) begin
        b1_r <= b2_r;
        b2_r <= b3_r;
        left_r <= left_r - 2'h1;
        done <= tx_last;
      end
    end
  end
endmodule
`default_nettype wire
